// >>> hdl/oarm_pkg.sv
// package of shared constants and types for operand address register modes
package oarm_pkg;
	// ---------------------------------------------------------------
	// addressing modes
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		OARM_MODE_TWO = 3'h1,
		OARM_MODE_THREE = 3'h2,
		OARM_MODE_FOUR = 3'h4
	} oarm_mode_type;

	// ---------------------------------------------------------------
	// field widths and layout
	// ---------------------------------------------------------------
	localparam int OARM_CHAR_W = 6;
	localparam int OARM_REG_MIN_W = 12;
	localparam int OARM_REG_MAX_W = 19;
	localparam int OARM_TWO_ADDR_W = 12;
	localparam int OARM_THREE_ADDR_W = 15;
	localparam int OARM_FOUR_ADDR_W = 19;
	localparam int OARM_THREE_MOD_W = 3;
	localparam int OARM_FOUR_MOD_W = 5;
	localparam int OARM_RAW_W = 24;
	localparam int OARM_MAX_INSTR_CHARS = 12;
	localparam int OARM_INDEX_TOTAL = 120;
	localparam int OARM_INDEX_AVAIL = 30;

	// ---------------------------------------------------------------
	// modifier encodings
	// ---------------------------------------------------------------
	localparam logic [2:0] OARM_MOD3_DIRECT = 3'h0;
	localparam logic [2:0] OARM_MOD3_INDIRECT = 3'h7;
	localparam logic [4:0] OARM_MOD5_DIRECT = 5'h00;
	localparam logic [4:0] OARM_MOD5_INDIRECT = 5'h10;

	typedef enum logic [1:0] {
		OARM_MOD_DIRECT = 2'h0,
		OARM_MOD_INDIRECT = 2'h1,
		OARM_MOD_INDEXED = 2'h2
	} oarm_modkind_type;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam oarm_mode_type OARM_MODE_RST = OARM_MODE_TWO;
	localparam logic [OARM_REG_MAX_W-1:0] OARM_REG_RST = 19'h00000;
endpackage

// >>> hdl/oarm_step_if.sv
// interface carrying one operand register stepping request and result
`timescale 1ns/100ps
interface oarm_step_if;
	import oarm_pkg::*;
	logic [OARM_REG_MAX_W-1:0] cur;
	logic [OARM_REG_MAX_W-1:0] nxt;
	oarm_mode_type mode;
	logic dec;
	logic channel;
	modport master (output cur, output mode, output dec, output channel, input nxt);
	modport stepper (input cur, input mode, input dec, input channel, output nxt);
endinterface

// >>> hdl/oarm_stepper.sv
// stepping unit: increment or decrement with bank, sector or full carry
`timescale 1ns/100ps
module oarm_stepper
	import oarm_pkg::*;
#(
	parameter int REG_W = OARM_REG_MAX_W
) (
	oarm_step_if.stepper st
);
	logic [REG_W-1:0] full_d;
	logic [REG_W-1:0] mask;
	logic [REG_W-1:0] stepped;

	always_comb begin
		if (st.dec) begin
			full_d = st.cur[REG_W-1:0] - REG_W'(1);
		end else begin
			full_d = st.cur[REG_W-1:0] + REG_W'(1);
		end
	end

	// ---------------------------------------------------------------
	// wrap mask: bits allowed to change
	// ---------------------------------------------------------------
	always_comb begin
		mask = '1;
		if (!st.channel) begin
			case (st.mode)
				OARM_MODE_TWO: begin
					mask = REG_W'((1 << OARM_TWO_ADDR_W) - 1);
				end
				OARM_MODE_THREE: begin
					mask = (REG_W >= OARM_THREE_ADDR_W) ? REG_W'((1 << OARM_THREE_ADDR_W) - 1) : '1;
				end
				OARM_MODE_FOUR: begin
					mask = '1;
				end
				default: begin
					mask = '1;
				end
			endcase
		end
	end

	assign stepped = (full_d & mask) | (st.cur[REG_W-1:0] & ~mask);
	assign st.nxt = OARM_REG_MAX_W'(stepped);
endmodule

// >>> hdl/oarm_top.sv
// operand address registers with two-, three- and four-character modes
`timescale 1ns/100ps
module oarm_top
	import oarm_pkg::*;
#(
	parameter int REG_W = OARM_REG_MAX_W
) (
	input wire logic clock_in,
	input wire logic nrst_in,
	input wire logic mode_wr_in,
	input wire oarm_mode_type mode_in,
	input wire logic load_a_in,
	input wire logic load_b_in,
	input wire logic dup_a_in,
	input wire logic [OARM_RAW_W-1:0] raw_addr_in,
	input wire logic step_a_in,
	input wire logic step_b_in,
	input wire logic step_dec_in,
	input wire logic step_channel_in,
	input wire logic [OARM_CHAR_W-1:0] op_char_in,
	input wire logic [1:0] format_addrs_in,
	input wire logic [1:0] format_extra_in,
	output logic [OARM_REG_MAX_W-1:0] a_operand_address_reg_out,
	output logic [OARM_REG_MAX_W-1:0] b_operand_address_reg_out,
	output oarm_mode_type mode_out,
	output oarm_modkind_type mod_kind_out,
	output logic [3:0] index_sel_out,
	output logic index_upper_out,
	output logic [3:0] instr_len_out,
	output logic [OARM_CHAR_W-1:0] op_code_out
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	oarm_mode_type mode_q;
	logic [OARM_REG_MAX_W-1:0] a_operand_address_reg_q;
	logic [OARM_REG_MAX_W-1:0] b_reg_q;
	logic [OARM_REG_MAX_W-1:0] load_d;
	logic [OARM_REG_MAX_W-1:0] keep_mask;
	logic [OARM_REG_MAX_W-1:0] width_mask;
	oarm_modkind_type kind_q;
	oarm_modkind_type kind_d;
	logic [3:0] idx_q;
	logic [3:0] idx_d;
	logic upper_q;
	logic upper_d;
	logic [3:0] len_q;
	logic [3:0] len_d;
	logic [4:0] len_sum;
	logic [OARM_CHAR_W-1:0] op_q;
	logic [OARM_REG_MAX_W-1:0] a_step_nxt;
	logic [OARM_REG_MAX_W-1:0] b_step_nxt;
	logic [2:0] mod3;
	logic [4:0] mod5;
	logic [2:0] addr_chars;

	assign width_mask = OARM_REG_MAX_W'((1 << REG_W) - 1);
	assign mod3 = raw_addr_in[OARM_THREE_ADDR_W +: OARM_THREE_MOD_W];
	assign mod5 = raw_addr_in[OARM_FOUR_ADDR_W +: OARM_FOUR_MOD_W];

	// ---------------------------------------------------------------
	// addressing mode register
	// ---------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			mode_q <= OARM_MODE_RST;
		end else if (mode_wr_in) begin
			case (mode_in)
				OARM_MODE_TWO, OARM_MODE_THREE, OARM_MODE_FOUR: begin
					mode_q <= mode_in;
				end
				default: begin
					mode_q <= mode_q;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// extraction load value and preserved bits
	// ---------------------------------------------------------------
	always_comb begin
		load_d = '0;
		keep_mask = '0;
		case (mode_q)
			OARM_MODE_TWO: begin
				load_d = OARM_REG_MAX_W'(raw_addr_in[OARM_TWO_ADDR_W-1:0]);
				keep_mask = ~OARM_REG_MAX_W'((1 << OARM_TWO_ADDR_W) - 1);
			end
			OARM_MODE_THREE: begin
				load_d = OARM_REG_MAX_W'(raw_addr_in[OARM_THREE_ADDR_W-1:0]);
				keep_mask = ~OARM_REG_MAX_W'((1 << OARM_THREE_ADDR_W) - 1);
			end
			OARM_MODE_FOUR: begin
				load_d = raw_addr_in[OARM_FOUR_ADDR_W-1:0];
				keep_mask = '0;
			end
			default: begin
				load_d = '0;
				keep_mask = '0;
			end
		endcase
		if (dup_a_in) begin
			load_d = a_operand_address_reg_q;
			keep_mask = '0;
		end
	end

	// ---------------------------------------------------------------
	// stepping units
	// ---------------------------------------------------------------
	oarm_step_if a_st ();
	oarm_step_if b_st ();
	assign a_st.cur = a_operand_address_reg_q;
	assign a_st.mode = mode_q;
	assign a_st.dec = step_dec_in;
	assign a_st.channel = step_channel_in;
	assign a_step_nxt = a_st.nxt;
	assign b_st.cur = b_reg_q;
	assign b_st.mode = mode_q;
	assign b_st.dec = step_dec_in;
	assign b_st.channel = step_channel_in;
	assign b_step_nxt = b_st.nxt;

	oarm_stepper #(.REG_W(REG_W)) u_step_a (
		.st(a_st.stepper)
	);
	oarm_stepper #(.REG_W(REG_W)) u_step_b (
		.st(b_st.stepper)
	);

	// ---------------------------------------------------------------
	// operand address registers
	// ---------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			a_operand_address_reg_q <= OARM_REG_RST;
		end else if (load_a_in) begin
			a_operand_address_reg_q <= ((a_operand_address_reg_q & keep_mask) | (load_d & ~keep_mask)) & width_mask;
		end else if (step_a_in) begin
			a_operand_address_reg_q <= a_step_nxt & width_mask;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			b_reg_q <= OARM_REG_RST;
		end else if (load_b_in) begin
			b_reg_q <= ((b_reg_q & keep_mask) | (load_d & ~keep_mask)) & width_mask;
		end else if (step_b_in) begin
			b_reg_q <= b_step_nxt & width_mask;
		end
	end

	// ---------------------------------------------------------------
	// modifier decode during extraction
	// ---------------------------------------------------------------
	always_comb begin
		kind_d = OARM_MOD_DIRECT;
		idx_d = 4'h0;
		upper_d = 1'b0;
		case (mode_q)
			OARM_MODE_TWO: begin
				kind_d = OARM_MOD_DIRECT;
			end
			OARM_MODE_THREE: begin
				if (mod3 == OARM_MOD3_DIRECT) begin
					kind_d = OARM_MOD_DIRECT;
				end else if (mod3 == OARM_MOD3_INDIRECT) begin
					kind_d = OARM_MOD_INDIRECT;
				end else begin
					kind_d = OARM_MOD_INDEXED;
					idx_d = {1'b0, mod3};
				end
			end
			OARM_MODE_FOUR: begin
				if (mod5 == OARM_MOD5_DIRECT) begin
					kind_d = OARM_MOD_DIRECT;
				end else if (mod5 == OARM_MOD5_INDIRECT) begin
					kind_d = OARM_MOD_INDIRECT;
				end else begin
					kind_d = OARM_MOD_INDEXED;
					idx_d = mod5[3:0];
					upper_d = mod5[4];
				end
			end
			default: begin
				kind_d = OARM_MOD_DIRECT;
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			kind_q <= OARM_MOD_DIRECT;
			idx_q <= 4'h0;
			upper_q <= 1'b0;
		end else if ((load_a_in || load_b_in) && !dup_a_in) begin
			kind_q <= kind_d;
			idx_q <= idx_d;
			upper_q <= upper_d;
		end
	end

	// ---------------------------------------------------------------
	// instruction length and op code
	// ---------------------------------------------------------------
	always_comb begin
		case (mode_q)
			OARM_MODE_TWO: begin
				addr_chars = 3'h2;
			end
			OARM_MODE_THREE: begin
				addr_chars = 3'h3;
			end
			OARM_MODE_FOUR: begin
				addr_chars = 3'h4;
			end
			default: begin
				addr_chars = 3'h2;
			end
		endcase
		len_sum = 5'h01 + 5'(format_addrs_in) * 5'(addr_chars) + 5'(format_extra_in);
		if (len_sum > 5'(OARM_MAX_INSTR_CHARS)) begin
			len_d = 4'(OARM_MAX_INSTR_CHARS);
		end else begin
			len_d = len_sum[3:0];
		end
	end

	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			len_q <= 4'h1;
			op_q <= 6'h00;
		end else if (load_a_in || load_b_in) begin
			len_q <= len_d;
			op_q <= op_char_in;
		end
	end

	assign a_operand_address_reg_out = a_operand_address_reg_q;
	assign b_operand_address_reg_out = b_reg_q;
	assign mode_out = mode_q;
	assign mod_kind_out = kind_q;
	assign index_sel_out = idx_q;
	assign index_upper_out = upper_q;
	assign instr_len_out = len_q;
	assign op_code_out = op_q;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_two_load;
		mode_q == OARM_MODE_TWO && load_a_in && !dup_a_in;
	endsequence

	sequence s_three_load;
		mode_q == OARM_MODE_THREE && load_b_in && !dup_a_in;
	endsequence

	sequence s_four_step;
		mode_q == OARM_MODE_FOUR && step_a_in && !load_a_in && !step_dec_in;
	endsequence

	chk_bank_kept_load: assert property (@(posedge clock_in) disable iff (!nrst_in)
		s_two_load |=> ((a_operand_address_reg_q >> OARM_TWO_ADDR_W)
		== ($past(a_operand_address_reg_q) >> OARM_TWO_ADDR_W)))
		else $error("bank bits changed on two-character load");
	chk_bank_kept_step: assert property (@(posedge clock_in) disable iff (!nrst_in)
		(mode_q == OARM_MODE_TWO && step_a_in && !load_a_in && !step_channel_in)
		|=> (a_operand_address_reg_q >> OARM_TWO_ADDR_W) == ($past(a_operand_address_reg_q) >> OARM_TWO_ADDR_W))
		else $error("bank bits changed on internal step");
	chk_sector_kept: assert property (@(posedge clock_in) disable iff (!nrst_in)
		(mode_q == OARM_MODE_THREE && step_b_in && !load_b_in && !step_channel_in)
		|=> (b_reg_q >> OARM_THREE_ADDR_W) == ($past(b_reg_q) >> OARM_THREE_ADDR_W))
		else $error("sector bits changed on internal step");
	chk_channel_carry: assert property (@(posedge clock_in) disable iff (!nrst_in)
		(step_a_in && !load_a_in && step_channel_in && !step_dec_in)
		|=> a_operand_address_reg_q == (($past(a_operand_address_reg_q) + 19'h1) & width_mask))
		else $error("channel step did not carry fully");
	chk_four_load: assert property (@(posedge clock_in) disable iff (!nrst_in)
		(mode_q == OARM_MODE_FOUR && load_b_in && !dup_a_in)
		|=> b_reg_q == ($past(raw_addr_in[OARM_FOUR_ADDR_W-1:0]) & width_mask))
		else $error("four-character load not whole");
	chk_dup_a_copy: assert property (@(posedge clock_in) disable iff (!nrst_in)
		(load_b_in && dup_a_in) |=> b_reg_q == $past(a_operand_address_reg_q))
		else $error("duplicate-A did not copy whole register");
	chk_two_direct: assert property (@(posedge clock_in) disable iff (!nrst_in)
		s_two_load |=> mod_kind_out == OARM_MOD_DIRECT)
		else $error("modification in two-character mode");
	chk_mod3_indirect: assert property (@(posedge clock_in) disable iff (!nrst_in)
		(mode_q == OARM_MODE_THREE && load_a_in && !dup_a_in && mod3 == OARM_MOD3_INDIRECT)
		|=> mod_kind_out == OARM_MOD_INDIRECT)
		else $error("three-bit indirect not decoded");
	chk_mod5_indirect: assert property (@(posedge clock_in) disable iff (!nrst_in)
		(mode_q == OARM_MODE_FOUR && load_a_in && !dup_a_in && mod5 == OARM_MOD5_INDIRECT)
		|=> mod_kind_out == OARM_MOD_INDIRECT)
		else $error("five-bit indirect not decoded");
	chk_len_bound: assert property (@(posedge clock_in) disable iff (!nrst_in)
		instr_len_out >= 4'h1 && instr_len_out <= 4'(OARM_MAX_INSTR_CHARS))
		else $error("instruction length out of range");
	chk_sector_load: assert property (@(posedge clock_in) disable iff (!nrst_in)
		s_three_load |=> (b_reg_q >> OARM_THREE_ADDR_W) == ($past(b_reg_q) >> OARM_THREE_ADDR_W)
		&& b_reg_q[OARM_THREE_ADDR_W-1:0]
		== ($past(raw_addr_in[OARM_THREE_ADDR_W-1:0]) & width_mask[OARM_THREE_ADDR_W-1:0]))
		else $error("sector bits changed on three-character load");
	chk_four_carry: assert property (@(posedge clock_in) disable iff (!nrst_in)
		s_four_step |=> a_operand_address_reg_q == (($past(a_operand_address_reg_q) + 19'h1) & width_mask))
		else $error("four-character step did not carry fully");
	chk_mode_ignored: assert property (@(posedge clock_in) disable iff (!nrst_in)
		(mode_wr_in && mode_in != OARM_MODE_TWO && mode_in != OARM_MODE_THREE && mode_in != OARM_MODE_FOUR)
		|=> $stable(mode_out))
		else $error("invalid mode code was taken");
	chk_mod3_index: assert property (@(posedge clock_in) disable iff (!nrst_in)
		(mode_q == OARM_MODE_THREE && load_b_in && !dup_a_in
		&& mod3 != OARM_MOD3_DIRECT && mod3 != OARM_MOD3_INDIRECT)
		|=> mod_kind_out == OARM_MOD_INDEXED && index_sel_out == {1'b0, $past(mod3)})
		else $error("three-bit index not decoded");
	chk_mod5_index: assert property (@(posedge clock_in) disable iff (!nrst_in)
		(mode_q == OARM_MODE_FOUR && load_b_in && !dup_a_in
		&& mod5 != OARM_MOD5_DIRECT && mod5 != OARM_MOD5_INDIRECT)
		|=> mod_kind_out == OARM_MOD_INDEXED && index_sel_out == $past(mod5[3:0])
		&& index_upper_out == $past(mod5[4]))
		else $error("five-bit index not decoded");
	chk_op_capture: assert property (@(posedge clock_in) disable iff (!nrst_in)
		(load_a_in || load_b_in) |=> op_code_out == $past(op_char_in))
		else $error("op code character not captured");
	chk_dup_no_decode: assert property (@(posedge clock_in) disable iff (!nrst_in)
		(dup_a_in && (load_a_in || load_b_in)) |=> $stable(mod_kind_out))
		else $error("modifier decode updated on duplicate-A");
endmodule

// >>> tb/oarm_mem_model.sv
// stored operand address layout as held in main memory
`timescale 1ns/100ps
module oarm_mem_model
	import oarm_pkg::*;
(
	input wire oarm_mode_type mode_in,
	input wire logic [4:0] mod_in,
	input wire logic [18:0] loc_in,
	output logic [OARM_RAW_W-1:0] raw_out
);
	// ---------------------------------------------------------------
	// right-justified stored address for the active mode
	// ---------------------------------------------------------------
	always_comb begin
		case (mode_in)
			OARM_MODE_THREE: raw_out = {6'h00, mod_in[2:0], loc_in[14:0]};
			OARM_MODE_FOUR: raw_out = {mod_in, loc_in};
			default: raw_out = {12'h000, loc_in[11:0]};
		endcase
	end
endmodule

// >>> tb/oarm_top_bench.sv
// self-checking bench for the operand address registers
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module oarm_top_bench
	import oarm_pkg::*;
;
	logic clock_in = 1'b0;
	logic nrst_in = 1'b0;
	logic mode_wr_in = 1'b0;
	oarm_mode_type mode_in = OARM_MODE_TWO;
	logic load_a_in = 1'b0;
	logic load_b_in = 1'b0;
	logic dup_a_in = 1'b0;
	logic [OARM_RAW_W-1:0] raw_addr;
	logic step_a_in = 1'b0;
	logic step_b_in = 1'b0;
	logic step_dec_in = 1'b0;
	logic step_channel_in = 1'b0;
	logic [5:0] op_char_in = 6'h00;
	logic [1:0] format_addrs_in = 2'h0;
	logic [1:0] format_extra_in = 2'h0;
	logic [18:0] a_reg;
	logic [18:0] b_reg;
	oarm_mode_type mode_out;
	oarm_modkind_type mod_kind_out;
	logic [3:0] index_sel_out;
	logic index_upper_out;
	logic [3:0] instr_len_out;
	logic [5:0] op_code_out;
	logic [4:0] mod_s = 5'h00;
	logic [18:0] loc_s = 19'h00000;
	int miscompares = 0;
	int check_count = 0;
	logic [4:0] mods4 [6] = '{5'h00, 5'h10, 5'h01, 5'h0f, 5'h11, 5'h1f};

	// ---------------------------------------------------------------
	// clock, design and memory model
	// ---------------------------------------------------------------
	initial begin
		forever #5 clock_in = ~clock_in;
	end

	oarm_top i_dut (.clock_in(clock_in), .nrst_in(nrst_in), .mode_wr_in(mode_wr_in), .mode_in(mode_in),
		.load_a_in(load_a_in), .load_b_in(load_b_in), .dup_a_in(dup_a_in), .raw_addr_in(raw_addr),
		.step_a_in(step_a_in), .step_b_in(step_b_in), .step_dec_in(step_dec_in),
		.step_channel_in(step_channel_in), .op_char_in(op_char_in), .format_addrs_in(format_addrs_in),
		.format_extra_in(format_extra_in), .a_operand_address_reg_out(a_reg), .b_operand_address_reg_out(b_reg),
		.mode_out(mode_out), .mod_kind_out(mod_kind_out), .index_sel_out(index_sel_out),
		.index_upper_out(index_upper_out), .instr_len_out(instr_len_out), .op_code_out(op_code_out));

	oarm_mem_model i_mem (.mode_in(mode_out), .mod_in(mod_s), .loc_in(loc_s), .raw_out(raw_addr));

	// ---------------------------------------------------------------
	// drivers
	// ---------------------------------------------------------------
	task automatic tick();
		@(posedge clock_in);
		#1;
	endtask

	task automatic do_mode(input logic [2:0] m);
		mode_wr_in = 1'b1;
		mode_in = oarm_mode_type'(m);
		tick();
		mode_wr_in = 1'b0;
		tick();
	endtask

	task automatic do_load(input logic b, input logic dup, input logic [4:0] m, input logic [18:0] l);
		mod_s = m;
		loc_s = l;
		load_a_in = ~b;
		load_b_in = b;
		dup_a_in = dup;
		tick();
		load_a_in = 1'b0;
		load_b_in = 1'b0;
		dup_a_in = 1'b0;
		tick();
	endtask

	task automatic do_step(input logic b, input logic dec, input logic ch);
		step_a_in = ~b;
		step_b_in = b;
		step_dec_in = dec;
		step_channel_in = ch;
		tick();
		step_a_in = 1'b0;
		step_b_in = 1'b0;
		step_channel_in = 1'b0;
		tick();
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		`CHK(a_reg, 19'h00000)
		`CHK(b_reg, 19'h00000)
		`CHK(mode_out, OARM_MODE_TWO)
		`CHK(mod_kind_out, OARM_MOD_DIRECT)
		`CHK(instr_len_out, 4'h1)
		`CHK(op_code_out, 6'h00)
	endtask

	task automatic t_two();
		do_mode(3'h4);
		do_load(1'b0, 1'b0, 5'h10, 19'h20456);
		`CHK(a_reg, 19'h20456)
		`CHK(mod_kind_out, OARM_MOD_INDIRECT)
		do_mode(3'h1);
		`CHK(mode_out, OARM_MODE_TWO)
		do_load(1'b0, 1'b0, 5'h10, 19'h00fa0);
		`CHK(a_reg, 19'h20fa0)
		`CHK(mod_kind_out, OARM_MOD_DIRECT)
		do_load(1'b0, 1'b0, 5'h00, 19'h00000);
		do_step(1'b0, 1'b1, 1'b0);
		`CHK(a_reg, 19'h20fff)
		do_step(1'b0, 1'b0, 1'b0);
		`CHK(a_reg, 19'h20000)
		do_step(1'b0, 1'b1, 1'b1);
		`CHK(a_reg, 19'h1ffff)
		do_load(1'b1, 1'b1, 5'h00, 19'h00123);
		`CHK(b_reg, 19'h1ffff)
	endtask

	task automatic t_three();
		do_mode(3'h2);
		do_load(1'b0, 1'b0, 5'h00, 19'h00001);
		`CHK(a_reg, 19'h18001)
		do_step(1'b0, 1'b1, 1'b0);
		do_step(1'b0, 1'b1, 1'b0);
		`CHK(a_reg, 19'h1ffff)
		format_addrs_in = 2'h2;
		format_extra_in = 2'h1;
		for (int i = 0; i < 8; i++) begin
			op_char_in = 6'(i + 8);
			do_load(1'b1, 1'b0, 5'(i), 19'h00000);
			`CHK(mod_kind_out, (i == 0) ? OARM_MOD_DIRECT : (i == 7) ? OARM_MOD_INDIRECT : OARM_MOD_INDEXED)
			if (i > 0 && i < 7) begin
				`CHK(index_sel_out, 4'(i))
			end
			`CHK(op_code_out, 6'(i + 8))
			`CHK(instr_len_out, 4'h8)
		end
		do_load(1'b0, 1'b0, 5'h07, 19'h07fff);
		`CHK(mod_kind_out, OARM_MOD_INDIRECT)
		`CHK(a_reg, 19'h1ffff)
		do_step(1'b0, 1'b0, 1'b1);
		`CHK(a_reg, 19'h20000)
		do_step(1'b1, 1'b1, 1'b0);
		`CHK(b_reg, 19'h1ffff)
	endtask

	task automatic t_four();
		do_mode(3'h4);
		format_addrs_in = 2'h3;
		format_extra_in = 2'h0;
		foreach (mods4[i]) begin
			do_load(1'b1, 1'b0, mods4[i], 19'h00000);
			`CHK(mod_kind_out, (i == 0) ? OARM_MOD_DIRECT : (i == 1) ? OARM_MOD_INDIRECT : OARM_MOD_INDEXED)
			if (i > 1) begin
				`CHK(index_sel_out, mods4[i][3:0])
				`CHK(index_upper_out, mods4[i][4])
			end
		end
		`CHK(instr_len_out, 4'hc)
		do_load(1'b0, 1'b0, 5'h00, 19'h07fff);
		do_step(1'b0, 1'b0, 1'b0);
		`CHK(a_reg, 19'h08000)
	endtask

	task automatic t_refuse();
		do_mode(3'h3);
		`CHK(mode_out, OARM_MODE_FOUR)
		mod_s = 5'h00;
		loc_s = 19'h40000;
		load_a_in = 1'b1;
		step_a_in = 1'b1;
		step_b_in = 1'b1;
		step_dec_in = 1'b0;
		tick();
		load_a_in = 1'b0;
		step_a_in = 1'b0;
		step_b_in = 1'b0;
		`CHK(a_reg, 19'h40000)
		`CHK(b_reg, 19'h00001)
	endtask

	// ---------------------------------------------------------------
	// sequence, watchdog and verdict
	// ---------------------------------------------------------------
	task automatic end_sim();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge clock_in);
		#1 nrst_in = 1'b1;
		t_reset();
		t_two();
		t_three();
		t_four();
		t_refuse();
		end_sim();
	end

	initial begin
		#20000;
		miscompares++;
		end_sim();
	end
endmodule
